// >>> verilog/ccd_timing_pkg.sv
// Constants, states and pin bundle for the line readout timing generator
package ccd_timing_pkg;
	// Clock rate and pixel rates
	localparam int CLK_MHZ = 125;
	localparam int PIX_FAST_MHZ = 40;
	localparam int PIX_FULL_MHZ = 20;
	// Cycles per pixel (one full horizontal cycle), rounded up so the rate is never exceeded
	localparam int PIX_FAST_CYC = (CLK_MHZ + PIX_FAST_MHZ - 1) / PIX_FAST_MHZ;
	localparam int PIX_FULL_CYC = (CLK_MHZ + PIX_FULL_MHZ - 1) / PIX_FULL_MHZ;
	// Line geometry
	localparam int ROW_CELLS = 2124;
	localparam int COLUMNS = 2112;
	localparam int EMPTY_PIX = 12;
	localparam int DARK_PIX = 28;
	localparam int IMAGE_SINGLE = 2056;
	localparam int HALF_CELLS = 1068;
	localparam int IMAGE_DUAL = 1028;
	localparam int DARK_GUARD = 1;
	// Vertical pulse and resume delay, in ns
	localparam int VPULSE_NS = 1000;
	localparam int VPULSE_CYC = (VPULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int RESUME_NS = 1000;
	localparam int RESUME_CYC = (RESUME_NS * CLK_MHZ + 999) / 1000;
	// Software registers of the controller
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h1;
	localparam logic [3:0] ADDR_LINES = 4'h2;
	localparam int CTRL_START = 0;
	localparam int CTRL_DUAL = 1;
	localparam int CTRL_FULL = 2;
	localparam int CTRL_DUMP = 3;
	localparam int PW = 12;
	localparam int CW = 8;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b0_0001,
		ST_VXFER = 5'b0_0010,
		ST_RESUME = 5'b0_0100,
		ST_HCLK = 5'b0_1000,
		ST_DONE = 5'b1_0000
	} rd_state_t;

	// Sensor clock pins, all driven high-active as logic levels
	typedef struct packed {
		logic vertical_phase_one;
		logic vertical_phase_two;
		logic line_dump_gate;
		logic shutter_drain;
		logic left_storage_one;
		logic left_storage_two;
		logic left_barrier_one;
		logic left_barrier_two;
		logic right_storage_one;
		logic right_storage_two;
		logic right_barrier_one;
		logic right_barrier_two;
		logic reset_gate;
	} ccd_pins_t;

	// Pixel class tags for the sample strobe
	typedef enum logic [1:0] {
		PX_EMPTY = 2'h0,
		PX_DARK = 2'h1,
		PX_IMAGE = 2'h2,
		PX_DARK_REF = 2'h3
	} px_class_t;
endpackage : ccd_timing_pkg

// >>> verilog/pixel_classifier.sv
// Classifies a horizontal cycle index into empty, dark, dark reference or image
`timescale 1ns/1ps
module pixel_classifier import ccd_timing_pkg::*; #(
	parameter int EMPTY = EMPTY_PIX,
	parameter int DARK = DARK_PIX,
	parameter int IMAGE = IMAGE_SINGLE
) (
	// Cycle index and mode
	input wire logic [PW-1:0] idx_in,
	input wire logic dual_in,
	// Class of the pixel at that index
	output px_class_t cls_out
);
	// Dark columns, inner ones flagged as usable for zero level
	function automatic px_class_t dark_cls(input int pos);
		if (pos >= DARK_GUARD && pos < DARK - DARK_GUARD) begin
			dark_cls = PX_DARK_REF;
		end else begin
			dark_cls = PX_DARK;
		end
	endfunction : dark_cls

	// Order within a line: empty, dark, image, trailing dark in single mode
	always_comb begin
		int i;
		i = int'(idx_in);
		if (i < EMPTY) begin
			cls_out = PX_EMPTY;
		end else if (i < EMPTY + DARK) begin
			cls_out = dark_cls(i - EMPTY);
		end else if (dual_in || i < EMPTY + DARK + IMAGE) begin
			cls_out = PX_IMAGE;
		end else begin
			cls_out = dark_cls(i - EMPTY - DARK - IMAGE);
		end
	end
endmodule : pixel_classifier

// >>> verilog/ccd_line_readout_timing.sv
// Line readout timing generator driving the sensor clock pins
//
// Operation
// - Horizontal clocks halted H1 high, H2 low
// - Horizontal restart waits resume delay after vertical
// - Zero reference uses inner 26 dark columns
// - No shutter, vertical or dump pulses during readout
// - Single mode barrier wiring: right barriers crossed
// - Single mode issues 2124 horizontal cycles
// - Dual mode: phase signals drive like-named inputs
// - Dual mode issues 1068 cycles per output
// - Right barrier edges align with others
// - Reset gate pulses after each pixel sample
// - 40 MHz normally, 20 MHz for full range
// - Dual right line reversed and appended later
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module ccd_line_readout_timing import ccd_timing_pkg::*; #(
	parameter int ROW_LEN = ROW_CELLS,
	parameter int HALF_LEN = HALF_CELLS,
	parameter int VPULSE = VPULSE_CYC,
	parameter int RESUME = RESUME_CYC
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Software register port
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out,
	// Sensor clock pins
	output ccd_pins_t pins_out,
	// Sample strobe toward the video converters
	output logic sample_out,
	output logic right_valid_out,
	output px_class_t class_out,
	output logic [PW-1:0] index_out,
	output logic busy_out
);
	typedef struct packed {
		rd_state_t st;
		logic dual;
		logic full;
		logic dump;
		logic [PW-1:0] pix;
		logic [CW-1:0] sub;
		logic [CW-1:0] cnt;
		logic [15:0] lines;
		logic [31:0] rdata;
		ccd_pins_t pins;
		logic sample;
		logic rvalid;
		px_class_t cls;
		logic [PW-1:0] idx;
		logic busy;
	} state_t;

	state_t s_r;
	state_t s_nxt;
	px_class_t cls_w;
	logic [CW-1:0] ppc;
	logic [PW-1:0] nline;

	// Pixel index classified combinationally, registered before leaving
	pixel_classifier #(
		.EMPTY(EMPTY_PIX),
		.DARK(DARK_PIX),
		.IMAGE(IMAGE_SINGLE)
	) u_cls (
		.idx_in(s_r.pix),
		.dual_in(s_r.dual),
		.cls_out(cls_w)
	);

	// Horizontal pins from the two phase levels; the barrier mapping picks direction
	function automatic ccd_pins_t hmap(input ccd_pins_t p, input logic h1, input logic dual);
		ccd_pins_t q;
		q = p;
		q.left_storage_one = h1;
		q.left_barrier_one = h1;
		q.right_storage_one = h1;
		q.left_storage_two = ~h1;
		q.left_barrier_two = ~h1;
		q.right_storage_two = ~h1;
		// Same edge as the others since all come from one flop set
		if (dual) begin
			q.right_barrier_one = h1;
			q.right_barrier_two = ~h1;
		end else begin
			q.right_barrier_two = h1;
			q.right_barrier_one = ~h1;
		end
		return q;
	endfunction : hmap

	// Slower pixel rate when full charge range is wanted
	assign ppc = s_r.full ? CW'(PIX_FULL_CYC) : CW'(PIX_FAST_CYC);
	// Line length by mode
	assign nline = s_r.dual ? PW'(HALF_LEN) : PW'(ROW_LEN);

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = 32'h0000_0000;
		s_nxt.sample = 1'b0;
		s_nxt.rvalid = 1'b0;
		// Register reads answer one cycle later
		if (rd_in) begin
			case (addr_in)
				ADDR_CTRL: s_nxt.rdata = {28'h000_0000, s_r.dump, s_r.full, s_r.dual, 1'b0};
				ADDR_STATUS: s_nxt.rdata = {27'h000_0000, s_r.st};
				ADDR_LINES: s_nxt.rdata = {16'h0000, s_r.lines};
				default: s_nxt.rdata = 32'h0000_0000;
			endcase
		end
		// Mode bits are taken only while idle, so a line never changes mode midway
		if (wr_in && addr_in == ADDR_CTRL && s_r.st == ST_IDLE) begin
			s_nxt.dual = wdata_in[CTRL_DUAL];
			s_nxt.full = wdata_in[CTRL_FULL];
			s_nxt.dump = wdata_in[CTRL_DUMP];
			if (wdata_in[CTRL_START]) begin
				s_nxt.st = ST_VXFER;
				s_nxt.cnt = '0;
				s_nxt.pins.line_dump_gate = wdata_in[CTRL_DUMP];
			end
		end
		case (s_r.st)
			ST_IDLE: begin
				// Halt levels: phase one high, phase two low
				s_nxt.pins = hmap(s_nxt.pins, 1'b1, s_nxt.dual);
				s_nxt.pins.reset_gate = 1'b0;
			end
			ST_VXFER: begin
				// Horizontal clocks held halted while vertical pulses
				s_nxt.pins = hmap(s_r.pins, 1'b1, s_r.dual);
				s_nxt.cnt = s_r.cnt + CW'(1);
				if (int'(s_r.cnt) < VPULSE) begin
					s_nxt.pins.vertical_phase_one = 1'b1;
				end else if (int'(s_r.cnt) < 2 * VPULSE) begin
					s_nxt.pins.vertical_phase_one = 1'b0;
					s_nxt.pins.vertical_phase_two = 1'b1;
				end else begin
					s_nxt.pins.vertical_phase_two = 1'b0;
					s_nxt.st = ST_RESUME;
					s_nxt.cnt = '0;
				end
			end
			ST_RESUME: begin
				// Wait after the vertical falling edge before clocking
				s_nxt.cnt = s_r.cnt + CW'(1);
				if (int'(s_r.cnt) >= RESUME - 1) begin
					s_nxt.pins.line_dump_gate = 1'b0;
					s_nxt.st = s_r.dump ? ST_DONE : ST_HCLK;
					s_nxt.pix = '0;
					s_nxt.sub = '0;
				end
			end
			ST_HCLK: begin
				// Quiet vertical, shutter and dump pins while reading
				s_nxt.pins.vertical_phase_one = 1'b0;
				s_nxt.pins.vertical_phase_two = 1'b0;
				s_nxt.pins.line_dump_gate = 1'b0;
				s_nxt.pins.shutter_drain = 1'b0;
				s_nxt.sub = s_r.sub + CW'(1);
				// First half of the pixel: phase two high moves charge one cell
				s_nxt.pins = hmap(s_nxt.pins, s_r.sub >= (ppc >> 1), s_r.dual);
				s_nxt.pins.reset_gate = 1'b0;
				if (s_r.sub == (ppc >> 1) - CW'(1)) begin
					s_nxt.sample = 1'b1;
					s_nxt.rvalid = s_r.dual;
					s_nxt.cls = cls_w;
					s_nxt.idx = s_r.pix;
				end
				if (s_r.sub == (ppc >> 1)) begin
					s_nxt.pins.reset_gate = 1'b1;
				end
				if (s_r.sub == ppc - CW'(1)) begin
					s_nxt.sub = '0;
					s_nxt.pix = s_r.pix + PW'(1);
					if (s_r.pix == nline - PW'(1)) begin
						s_nxt.st = ST_DONE;
					end
				end
			end
			ST_DONE: begin
				s_nxt.lines = s_r.lines + 16'h0001;
				s_nxt.st = ST_IDLE;
				s_nxt.pins = hmap(s_r.pins, 1'b1, s_r.dual);
				s_nxt.pins.reset_gate = 1'b0;
			end
			default: s_nxt.st = ST_IDLE;
		endcase
		// Busy kept in a flop so the port never shows decode glitches
		s_nxt.busy = (s_nxt.st != ST_IDLE);
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			s_r <= '0;
			s_r.st <= ST_IDLE;
			s_r.pins.left_storage_one <= 1'b1;
			s_r.pins.left_barrier_one <= 1'b1;
			s_r.pins.right_storage_one <= 1'b1;
			s_r.pins.right_barrier_two <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs straight from the state flops
	assign rdata_out = s_r.rdata;
	assign pins_out = s_r.pins;
	assign sample_out = s_r.sample;
	assign right_valid_out = s_r.rvalid;
	assign class_out = s_r.cls;
	assign index_out = s_r.idx;
	assign busy_out = s_r.busy;
endmodule : ccd_line_readout_timing

// >>> testbench/ccd_readout_sva.sv
// Pin timing assertions for the line readout generator
`timescale 1ns/1ps
module ccd_readout_sva import ccd_timing_pkg::*; #(
	parameter int RESUME = 3
) (
	// Watched ports
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire ccd_pins_t pins_out,
	input wire logic sample_out,
	input wire logic right_valid_out,
	input wire px_class_t class_out
);
	logic [7:0] gap_r;
	wire s1 = pins_out.left_storage_one;
	wire s2 = pins_out.left_storage_two;
	wire vp = pins_out.vertical_phase_one | pins_out.vertical_phase_two;
	// Cycles since the vertical pulse ended; saturates so long idles never wrap
	always_ff @(posedge clk_sys_in) begin
		if (rst_in || pins_out.vertical_phase_two) gap_r <= 8'h00;
		else if (gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	a_halt_in_vert: assert property (
		vp |-> s1 && !s2) else $error("horizontal not halted");
	a_resume_gap: assert property (
		$fell(s1) |-> gap_r >= RESUME) else $error("horizontal resumed early");
	a_quiet_readout: assert property (
		pins_out.reset_gate |-> !vp && !pins_out.line_dump_gate && !pins_out.shutter_drain)
		else $error("pulse during readout");
	a_phase_wiring: assert property (
		pins_out.left_barrier_one == s1 && pins_out.right_storage_one == s1
		&& pins_out.left_barrier_two == s2 && pins_out.right_storage_two == s2)
		else $error("storage or barrier wiring");
	a_barrier_edges: assert property (
		$changed(s1) |-> $changed(pins_out.right_barrier_one)
		&& pins_out.right_barrier_one != pins_out.right_barrier_two) else $error("barrier edge");
	a_phase_complement: assert property (
		s1 != s2) else $error("phases not complementary");
	a_reset_after_sample: assert property (
		sample_out |=> pins_out.reset_gate) else $error("no reset gate after sample");
	a_pixel_rate: assert property (
		sample_out |=> !sample_out [*3]) else $error("pixel rate too high");
	a_right_with_sample: assert property (
		right_valid_out |-> sample_out) else $error("right valid alone");
	// Main scenarios
	c_dual: cover property (sample_out && right_valid_out);
	c_dump: cover property ($rose(pins_out.line_dump_gate));
	c_dark_ref: cover property (sample_out && class_out == PX_DARK_REF);
endmodule : ccd_readout_sva
bind ccd_line_readout_timing ccd_readout_sva #(.RESUME(RESUME)) sva_u (.clk_sys_in, .rst_in,
	.pins_out, .sample_out, .right_valid_out, .class_out);

// >>> testbench/ccd_sensor_model.sv
// Behavioural sensor: loads or dumps rows and counts cell shifts
`timescale 1ns/1ps
module ccd_sensor_model import ccd_timing_pkg::*; (
	// Clock and sensor pins
	input wire logic clk_sys_in,
	input wire ccd_pins_t pins_in,
	// Line tallies
	output int loaded_out,
	output int dumped_out,
	output int shifted_out
);
	logic v2_r = 1'b0;
	logic dump_r = 1'b0;
	logic h1_r = 1'b1;
	initial loaded_out = 0;
	initial dumped_out = 0;
	initial shifted_out = 0;
	// Transfer ends at the fall of phase two; dump gate seen meanwhile discards it
	always @(posedge clk_sys_in) begin
		v2_r <= pins_in.vertical_phase_two;
		h1_r <= pins_in.left_storage_one;
		if (pins_in.vertical_phase_one) dump_r <= pins_in.line_dump_gate;
		else if (pins_in.vertical_phase_two && pins_in.line_dump_gate) dump_r <= 1'b1;
		if (v2_r && !pins_in.vertical_phase_two) begin
			if (dump_r) dumped_out <= dumped_out + 1;
			else loaded_out <= loaded_out + 1;
			shifted_out <= 0;
		end
		// Each storage-one rise moves both halves one cell on
		if (!h1_r && pins_in.left_storage_one) shifted_out <= shifted_out + 1;
	end
endmodule : ccd_sensor_model

// >>> testbench/testbench.sv
// Self-checking bench for the line readout timing generator
`timescale 1ns/1ps
module testbench import ccd_timing_pkg::*;;
	logic clk_sys_in = 1'b0;
	logic rst_in = 1'b1;
	logic [3:0] addr_in = 4'h0;
	logic [31:0] wdata_in = 32'h0000_0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [31:0] rdata_out;
	ccd_pins_t pins_out;
	logic sample_out, right_valid_out, busy_out, dual_r;
	px_class_t class_out;
	logic [PW-1:0] index_out, exp_idx;
	int loaded, dumped, shifted, nsamp, lines = 0, fails = 0, n_checks = 0, seed = 32'ha5f1;
	ccd_line_readout_timing #(.VPULSE(2), .RESUME(3)) dut_u (.clk_sys_in, .rst_in, .addr_in,
		.wdata_in, .wr_in, .rd_in, .rdata_out, .pins_out, .sample_out, .right_valid_out,
		.class_out, .index_out, .busy_out);
	ccd_sensor_model sensor_u (.clk_sys_in, .pins_in(pins_out), .loaded_out(loaded),
		.dumped_out(dumped), .shifted_out(shifted));
	initial forever #4 clk_sys_in = ~clk_sys_in;
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out
	function automatic px_class_t exp_cls(input int i, input logic dual);
		int d = EMPTY_PIX + DARK_PIX;
		int r = d + IMAGE_SINGLE;
		if (i < EMPTY_PIX) return PX_EMPTY;
		if (i == EMPTY_PIX || i == d - 1 || i == r || i == ROW_CELLS - 1) return PX_DARK;
		if (i < d || (!dual && i > r)) return PX_DARK_REF;
		return PX_IMAGE;
	endfunction : exp_cls
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		@(negedge clk_sys_in);
		d = rdata_out;
	endtask : rd
	// Every sample must walk the line in order with the right class
	always @(negedge clk_sys_in) begin
		if (sample_out === 1'b1) begin
			chk("index", index_out, exp_idx);
			chk("class", class_out, exp_cls(exp_idx, dual_r));
			chk("right valid", right_valid_out, dual_r);
			exp_idx <= exp_idx + 1'b1;
			nsamp <= nsamp + 1;
		end
	end
	// One line; the repeated start while busy must be ignored
	task automatic run_line(input logic [3:0] mode);
		logic [31:0] d;
		int ld;
		int n;
		ld = loaded;
		n = mode[CTRL_DUMP] ? 0 : (mode[CTRL_DUAL] ? HALF_CELLS : ROW_CELLS);
		dual_r = mode[CTRL_DUAL];
		exp_idx = '0;
		nsamp = 0;
		wr(ADDR_CTRL, {28'h000_0000, mode | 4'h1});
		wr(ADDR_CTRL, 32'h0000_0001);
		chk("busy", busy_out, 1'b1);
		for (int k = 0; k < 20000 && busy_out !== 1'b0; k++) @(negedge clk_sys_in);
		if (busy_out !== 1'b0) begin
			fails++;
			close_out();
		end
		lines++;
		chk("pixels", nsamp, n);
		chk("cells", shifted, n);
		chk("loaded", loaded - ld, !mode[CTRL_DUMP]);
		rd(ADDR_LINES, d);
		chk("lines", d[15:0], lines);
		rd(ADDR_CTRL, d);
		chk("ctrl", d, {28'h000_0000, mode & 4'hE});
		rd(ADDR_STATUS, d);
		chk("status", d[4:0], ST_IDLE);
		rd(4'hF, d);
		chk("unmapped", d, 32'h0000_0000);
	endtask : run_line
	// Fixed corner modes back to back, then random ones
	initial begin
		logic [3:0] modes [5] = '{4'h0, 4'h6, 4'h8, 4'hA, 4'h4};
		repeat (8) @(posedge clk_sys_in);
		rst_in <= 1'b0;
		foreach (modes[i]) run_line(modes[i]);
		repeat (2) run_line(4'($random(seed)) & 4'hE);
		close_out();
	end
endmodule : testbench
